/* File: design/pbctl_pkg.sv */
// Constants, types and helpers shared by the push-button power controller
// Behaviour
// RQ1 - Long push needs both buttons held for extra delay ending at cap threshold
// RQ2 - Without delay capacitor, long push is recognised right after minimum interrupt time
// RQ3 - Power enable only if supply stays above upper threshold for whole debounce
// RQ4 - Short press raises interrupt; long two-button push pulses reset or drops enable
// RQ5 - Supply-low output asserted below upper threshold at power-up, on undervoltage later
// RQ6 - Supply-low output released in standby
// RQ7 - Button state low during debounce, then at least minimum interrupt time, then follows button
// RQ8 - Button state ignores presses during undervoltage
// RQ9 - Fixed-window variant: button state answers only first startup press until window ends
// RQ10 - Enable asserted after press held for debounce with supply above upper threshold
// RQ11 - At startup enable drops on release without hold, or window expiry without hold
// RQ12 - In normal operation enable drops when hold input goes low
// RQ13 - Enable drops when undervoltage lasts debounce plus minimum interrupt plus extra delay
// RQ14 - Drop option drops enable on long push; reset option needs hold within window
// RQ15 - Polarity option inverts enable output; enable output is push-pull
// RQ16 - At startup after qualified press reset is driven low for recovery time
// RQ17 - Reset option drives reset low for recovery time after long push
// RQ18 - Normal operation with hold high: interrupt low when supply below lower threshold
// RQ19 - Normal operation: interrupt low after qualified press, held while button pressed
// RQ20 - Interrupt stays high throughout power-up
// RQ21 - Each interrupt pulse lasts at least the minimum interrupt time
// RQ22 - Outside party drives power button only by pulling it to ground
// RQ23 - In standby only a falling edge of the power button is watched
// RQ24 - Supply dip during startup debounce clears the count, restarting when supply returns
// RQ25 - Hold-required variant samples hold at window expiry when button still pressed
// RQ26 - All timing on one clock; comparator results enter through synchronisers
package pbctl_pkg;

  // Clock rate in MHz and times in microseconds
  localparam int unsigned CLK_MHZ               = 100;
  localparam int unsigned PRESS_QUALIFY_TIME_US = 32000;
  localparam int unsigned INT_MIN_TIME_US       = 32000;
  localparam int unsigned RESET_PULSE_TIME_US   = 210000;
  localparam int unsigned CONFIRM_WINDOW_US     = 2000000;

  // Counter width for every interval
  localparam int unsigned CNT_W = 32;
  typedef logic [CNT_W-1:0] cnt_t;

  // Synchroniser lanes and their idle values (buttons released, hold low)
  localparam int unsigned SYN_N    = 7;
  localparam int unsigned SYN_BTN  = 0;
  localparam int unsigned SYN_SEC  = 1;
  localparam int unsigned SYN_UP   = 2;
  localparam int unsigned SYN_LO   = 3;
  localparam int unsigned SYN_FIT  = 4;
  localparam int unsigned SYN_HIT  = 5;
  localparam int unsigned SYN_HOLD = 6;
  localparam logic [SYN_N-1:0] SYN_IDLE = 7'h03;

  // Open-drain output: level as a push-pull pin would show it, and pull-down enable
  typedef struct packed {
    logic drive_n;
    logic oe;
  } od_pin_t;

  typedef enum {ST_STANDBY, ST_QUALIFY, ST_STARTUP, ST_RUN, ST_RECONFIRM} pwr_state_t;

  // Microseconds to clock cycles; exact at an integer MHz rate
  function automatic cnt_t us_to_cycles(input int unsigned us);
    return cnt_t'(us * CLK_MHZ);
  endfunction

  // Saturating step helpers for the interval counters
  function automatic cnt_t inc_sat(input cnt_t c);
    return (c == {CNT_W{1'b1}}) ? c : cnt_t'(c + cnt_t'(1));
  endfunction

  function automatic cnt_t dec_sat(input cnt_t c);
    return (c == cnt_t'(0)) ? c : cnt_t'(c - cnt_t'(1));
  endfunction

endpackage

/* File: design/pushbutton_power_controller.sv */
// Push-button power sequencer: qualifies buttons and supply, drives enable, reset, interrupt, status
`timescale 1ns/1ps
module pushbutton_power_controller #(
  parameter bit              HOLD_REQUIRED   = 1'b1, // 1: button held until hold confirm; 0: fixed window
  parameter bit              LONG_PUSH_RESET = 1'b1, // 1: long push pulses reset; 0: drops enable
  parameter bit              EN_ACTIVE_LOW   = 1'b0, // Polarity option of the enable output
  parameter pbctl_pkg::cnt_t DEB_CYC = pbctl_pkg::us_to_cycles(pbctl_pkg::PRESS_QUALIFY_TIME_US),
  parameter pbctl_pkg::cnt_t INT_CYC = pbctl_pkg::us_to_cycles(pbctl_pkg::INT_MIN_TIME_US),
  parameter pbctl_pkg::cnt_t REC_CYC = pbctl_pkg::us_to_cycles(pbctl_pkg::RESET_PULSE_TIME_US),
  parameter pbctl_pkg::cnt_t WIN_CYC = pbctl_pkg::us_to_cycles(pbctl_pkg::CONFIRM_WINDOW_US)
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Buttons, comparators and hold confirm (asynchronous)
  input  wire logic          power_button_n,
  input  wire logic          second_button_n,
  input  wire logic          supply_above_upper,
  input  wire logic          supply_above_lower,
  input  wire logic          long_push_delay_cap_fitted,
  input  wire logic          delay_cap_threshold_hit,
  input  wire logic          hold_confirm_in,
  // Push-pull outputs
  output logic               enable_out,
  output logic               delay_cap_charge_current_en,
  // Open-drain outputs
  output pbctl_pkg::od_pin_t reset_n,
  output pbctl_pkg::od_pin_t int_n,
  output pbctl_pkg::od_pin_t supply_low_n,
  output pbctl_pkg::od_pin_t button_state_n
);
  import pbctl_pkg::*;

  localparam cnt_t LP_BASE = cnt_t'(DEB_CYC + INT_CYC);

  // Two-flop synchronisers; only sync_q is read by logic
  logic [SYN_N-1:0] meta_q;
  logic [SYN_N-1:0] sync_q;
  logic             btn_prev_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q    <= SYN_IDLE;
      sync_q    <= SYN_IDLE;
      btn_prev_q <= 1'b1;
    end else begin
      meta_q    <= {hold_confirm_in, delay_cap_threshold_hit, long_push_delay_cap_fitted,
                    supply_above_lower, supply_above_upper, second_button_n, power_button_n}; // [RQ26]
      sync_q    <= meta_q;
      btn_prev_q <= sync_q[SYN_BTN];
    end
  end

  // Decoded inputs
  wire btn_dn  = !sync_q[SYN_BTN];
  wire both_dn = btn_dn && !sync_q[SYN_SEC];
  wire up_ok   = sync_q[SYN_UP];
  wire uv      = !sync_q[SYN_LO];
  wire cap_fit = sync_q[SYN_FIT];
  wire cap_hit = sync_q[SYN_HIT];
  wire hold    = sync_q[SYN_HOLD];
  wire btn_fall = btn_prev_q && btn_dn;

  // State and counters
  pwr_state_t state_q, state_d;
  cnt_t       tmr_q, tmr_d;
  cnt_t       press_q, press_d;
  cnt_t       lp_q, lp_d;
  cnt_t       uv_q, uv_d;
  cnt_t       int_cnt_q, int_cnt_d;
  cnt_t       bs_cnt_q, bs_cnt_d;
  cnt_t       rst_cnt_q, rst_cnt_d;
  logic       lp_done_q;
  logic       seen_rel_q;

  // Phase decode
  wire in_run     = (state_q == ST_RUN);
  wire in_powerup = (state_q == ST_QUALIFY) || (state_q == ST_STARTUP);
  wire en_act     = (state_q == ST_STARTUP) || in_run || (state_q == ST_RECONFIRM);

  // Startup debounce only advances while the supply is good and the button is down
  wire qual_done = (state_q == ST_QUALIFY) && btn_dn && up_ok
                   && (tmr_q >= cnt_t'(DEB_CYC - cnt_t'(1))); // [RQ3] [RQ10]
  wire win_done  = (tmr_q >= cnt_t'(WIN_CYC - cnt_t'(1)));

  // Extra long-push delay: the external capacitor charges once the base time has run;
  // without a capacitor the delay is zero
  wire  lp_base   = both_dn && (lp_q >= LP_BASE);
  wire  uv_base   = (uv_q >= LP_BASE);
  wire  cap_ready = !cap_fit || cap_hit;                      // [RQ2]
  wire  long_push = in_run && lp_base && cap_ready && !lp_done_q; // [RQ1] [RQ4]
  wire  uv_drop   = in_run && uv_base && cap_ready;           // [RQ13]
  wire  charge_d  = cap_fit && in_run && (lp_base || uv_base);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (btn_fall) state_d = ST_QUALIFY; // [RQ23]
      end
      ST_QUALIFY: begin
        if (!btn_dn) state_d = ST_STANDBY;
        else if (qual_done) state_d = ST_STARTUP; // [RQ10]
      end
      ST_STARTUP: begin
        if (win_done || (HOLD_REQUIRED && !btn_dn)) state_d = hold ? ST_RUN : ST_STANDBY; // [RQ11] [RQ25]
      end
      ST_RUN: begin
        if (!hold || uv_drop) state_d = ST_STANDBY; // [RQ12] [RQ13]
        else if (long_push) state_d = LONG_PUSH_RESET ? ST_RECONFIRM : ST_STANDBY; // [RQ14]
      end
      ST_RECONFIRM: begin
        if (hold && (rst_cnt_q == cnt_t'(0))) state_d = ST_RUN;
        else if (win_done) state_d = ST_STANDBY; // [RQ14]
      end
      default: state_d = ST_STANDBY;
    endcase
  end

  // State timer: startup debounce, then confirmation window; cleared on a supply dip during debounce
  assign tmr_d = (state_d != state_q) ? cnt_t'(0) :
                 ((state_q == ST_QUALIFY) && !up_ok) ? cnt_t'(0) : inc_sat(tmr_q); // [RQ24]

  // Press, long-push and undervoltage duration counters
  assign press_d = btn_dn ? inc_sat(press_q) : cnt_t'(0);
  assign lp_d    = (both_dn && in_run) ? inc_sat(lp_q) : cnt_t'(0);
  assign uv_d    = (uv && in_run) ? inc_sat(uv_q) : cnt_t'(0);

  // Interrupt: cause sampled only in normal operation with hold high; pulse stretched to minimum
  wire btn_qual = btn_dn && (press_q >= DEB_CYC);
  wire int_req  = in_run && hold && (uv || btn_qual); // [RQ18] [RQ19]
  assign int_cnt_d = in_powerup ? cnt_t'(0) :
                     (int_req && !int_n.oe) ? cnt_t'(INT_CYC - cnt_t'(1)) : dec_sat(int_cnt_q); // [RQ21]
  wire int_act = !in_powerup && (int_req || (int_cnt_q != cnt_t'(0))); // [RQ20]

  // Button state: follows the press during debounce, then held low at least the minimum time.
  // The fixed-window variant ignores every press after the first release until the window ends.
  wire bs_resp = (state_q != ST_STANDBY) && !uv                              // [RQ8]
                 && !(!HOLD_REQUIRED && (state_q == ST_STARTUP) && seen_rel_q); // [RQ9]
  wire bs_qual = bs_resp && btn_dn && (press_q == cnt_t'(DEB_CYC - cnt_t'(1)));
  assign bs_cnt_d = bs_qual ? INT_CYC : dec_sat(bs_cnt_q); // [RQ7]
  wire bs_act = (bs_resp && btn_dn) || (bs_cnt_q != cnt_t'(0)); // [RQ7]

  // Reset pulse on power-up and, with the reset option, on long push
  wire rst_start = ((state_q == ST_QUALIFY) && (state_d == ST_STARTUP)) // [RQ16]
                   || (LONG_PUSH_RESET && long_push && (state_d == ST_RECONFIRM)); // [RQ17]
  assign rst_cnt_d = rst_start ? REC_CYC : dec_sat(rst_cnt_q);

  // Supply-low: upper threshold during power-up, undervoltage afterwards, released in standby
  wire sl_drive = (state_q != ST_STANDBY); // [RQ6]
  wire sl_act   = in_powerup ? !up_ok : uv; // [RQ5]

  // Registers of state and counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_STANDBY;
      tmr_q     <= '0;
      press_q   <= '0;
      lp_q      <= '0;
      uv_q      <= '0;
      int_cnt_q <= '0;
      bs_cnt_q  <= '0;
      rst_cnt_q <= '0;
    end else begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      press_q   <= press_d;
      lp_q      <= lp_d;
      uv_q      <= uv_d;
      int_cnt_q <= int_cnt_d;
      bs_cnt_q  <= bs_cnt_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // One long push per hold of the buttons; first-release memory of the startup window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lp_done_q  <= 1'b0;
      seen_rel_q <= 1'b0;
    end else begin
      lp_done_q  <= both_dn && (lp_done_q || long_push);
      seen_rel_q <= (state_q == ST_STARTUP) && (seen_rel_q || !btn_dn);
    end
  end

  // Output flops; the enable is push-pull and inverted by the polarity option
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_out                  <= EN_ACTIVE_LOW;
      delay_cap_charge_current_en <= 1'b0;
      reset_n                     <= '{drive_n: 1'b1, oe: 1'b0};
      int_n                       <= '{drive_n: 1'b1, oe: 1'b0};
      supply_low_n                <= '{drive_n: 1'b1, oe: 1'b0};
      button_state_n              <= '{drive_n: 1'b1, oe: 1'b0};
    end else begin
      enable_out                  <= en_act ^ EN_ACTIVE_LOW; // [RQ15]
      delay_cap_charge_current_en <= charge_d;
      reset_n                     <= '{drive_n: rst_cnt_q == cnt_t'(0), oe: rst_cnt_q != cnt_t'(0)};
      int_n                       <= '{drive_n: !int_act, oe: int_act};
      supply_low_n                <= '{drive_n: !(sl_drive && sl_act), oe: sl_drive && sl_act};
      button_state_n              <= '{drive_n: !bs_act, oe: bs_act};
    end
  end

  // Helper lengths of the reset and interrupt pulses, read only by the checks below
  cnt_t rst_len_q;
  cnt_t int_len_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_len_q <= '0;
      int_len_q <= '0;
    end else begin
      rst_len_q <= reset_n.oe ? inc_sat(rst_len_q) : cnt_t'(0);
      int_len_q <= int_n.oe ? inc_sat(int_len_q) : cnt_t'(0);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Power-up entry: a qualified startup press, then enable two edges later
  sequence s_qualified;
    (state_q == ST_QUALIFY) && qual_done;
  endsequence
  sequence s_enable_on;
    (state_q == ST_STARTUP) ##1 (enable_out == !EN_ACTIVE_LOW);
  endsequence

  a_enable_entry: assert property (s_qualified |=> s_enable_on) // [RQ10]
    else $error("enable not asserted after qualified startup press");
  a_enable_cause: assert property ($rose(state_q == ST_STARTUP) |-> $past(up_ok) && $past(btn_dn)) // [RQ3]
    else $error("startup entered without good supply and pressed button");
  a_debounce_clear: assert property ((state_q == ST_QUALIFY) && !up_ok && (state_d == ST_QUALIFY) // [RQ24]
                                     |=> tmr_q == cnt_t'(0))
    else $error("debounce count not cleared on supply dip");
  a_reset_startup: assert property ($rose(state_q == ST_STARTUP) |=> reset_n.oe [*2]) // [RQ16]
    else $error("reset not driven after power-up qualification");
  a_reset_width: assert property ($fell(reset_n.oe) |-> rst_len_q >= REC_CYC) // [RQ16]
    else $error("reset pulse shorter than recovery time");
  a_int_powerup: assert property (in_powerup |=> !int_n.oe) // [RQ20]
    else $error("interrupt asserted during power-up");
  a_int_width: assert property ($fell(int_n.oe) && !$past(in_powerup) |-> int_len_q >= INT_CYC) // [RQ21]
    else $error("interrupt pulse shorter than minimum");
  a_hold_drop: assert property (in_run && !hold // [RQ12]
                                |=> (state_q == ST_STANDBY) ##1 (enable_out == EN_ACTIVE_LOW))
    else $error("enable kept after hold went low");
  a_window_drop: assert property ((state_q == ST_STARTUP) && win_done && !hold // [RQ11]
                                  |=> state_q == ST_STANDBY)
    else $error("enable kept after window without hold");
  a_supply_release: assert property ((state_q == ST_STANDBY) |=> !supply_low_n.oe) // [RQ6]
    else $error("supply-low driven in standby");
  a_uv_drop: assert property (in_run && hold && uv && uv_base && cap_ready |=> state_q == ST_STANDBY) // [RQ13]
    else $error("enable kept after long undervoltage");

  // Supply-low follows the upper threshold at power-up and undervoltage later.
  // The pin is only pulled while awake, so a sleeping part costs no pull-up current.
  a_sl_powerup: assert property (in_powerup && !up_ok // [RQ5]
                                 |=> supply_low_n.oe)
    else $error("supply-low not driven while supply is short at power-up");
  a_sl_undervolt: assert property (in_run && uv // [RQ5]
                                   |=> supply_low_n.oe)
    else $error("supply-low not driven on undervoltage");

  // Button state: follows a press, blind during undervoltage and, in the fixed-window variant, after the first startup release
  a_bs_follow: assert property (bs_resp && btn_dn // [RQ7]
                                |=> button_state_n.oe)
    else $error("button state not following the press");
  a_bs_standby: assert property ((state_q == ST_STANDBY) && (bs_cnt_q == cnt_t'(0)) // [RQ7]
                                 |=> !button_state_n.oe)
    else $error("button state low in standby");
  a_bs_uv_blind: assert property (uv && (bs_cnt_q == cnt_t'(0)) // [RQ8]
                                  |=> !button_state_n.oe)
    else $error("button state moved during undervoltage");
  a_bs_window: assert property (!HOLD_REQUIRED && (state_q == ST_STARTUP) && seen_rel_q // [RQ9]
                                && (bs_cnt_q == cnt_t'(0)) |=> !button_state_n.oe)
    else $error("button state answered a second startup press");

  // Interrupt causes; without hold the host is not listening, so only a running pulse may finish
  a_int_press: assert property (in_run && hold && btn_qual // [RQ19]
                                |=> int_n.oe)
    else $error("interrupt missing while qualified press is held");
  a_int_uv: assert property (in_run && hold && uv // [RQ18]
                             |=> int_n.oe)
    else $error("interrupt missing on undervoltage");
  a_int_no_hold: assert property (in_run && !hold && (int_cnt_q == cnt_t'(0)) // [RQ18]
                                  |=> !int_n.oe)
    else $error("interrupt raised without hold");

  // Power path decisions
  a_standby_edge: assert property ((state_q == ST_STANDBY) && !btn_fall // [RQ23]
                                   |=> state_q == ST_STANDBY)
    else $error("standby left without a falling edge");
  a_qual_supply: assert property ((state_q == ST_QUALIFY) && !up_ok // [RQ3]
                                  |=> state_q != ST_STARTUP)
    else $error("startup entered while supply below threshold");
  a_release_drop: assert property ((state_q == ST_STARTUP) && HOLD_REQUIRED && !btn_dn && !hold // [RQ11]
                                   |=> state_q == ST_STANDBY)
    else $error("enable kept after release without hold");
  a_window_keep: assert property ((state_q == ST_STARTUP) && win_done && hold // [RQ25]
                                  |=> state_q == ST_RUN)
    else $error("hold at window end not honoured");
  a_en_level: assert property (en_act // [RQ15]
                               |=> enable_out == !EN_ACTIVE_LOW)
    else $error("enable level does not match polarity option");
  a_en_off: assert property (!en_act // [RQ15]
                             |=> enable_out == EN_ACTIVE_LOW)
    else $error("enable asserted while not powered");
  a_uv_short: assert property (in_run && hold && !uv_base && !long_push // [RQ13]
                               |=> state_q == ST_RUN)
    else $error("power dropped before undervoltage time ran out");

  // Long push; the reset option goes to reconfirm and then pulls reset low
  sequence s_reconfirm_reset;
    (state_q == ST_RECONFIRM) ##1 reset_n.oe;
  endsequence

  a_lp_cap_wait: assert property (in_run && cap_fit && !cap_hit // [RQ1]
                                  |=> state_q != ST_RECONFIRM)
    else $error("long push taken before capacitor threshold");
  a_lp_no_cap: assert property (in_run && hold && !uv_drop && !cap_fit && lp_base && !lp_done_q // [RQ2]
                                |=> state_q != ST_RUN)
    else $error("long push not taken without capacitor");
  a_lp_once: assert property (in_run && lp_done_q // [RQ4]
                              |=> state_q != ST_RECONFIRM)
    else $error("second long push taken within one hold");
  a_lp_reset: assert property (long_push && LONG_PUSH_RESET && hold && !uv_drop // [RQ17]
                               |=> s_reconfirm_reset)
    else $error("reset not pulsed after long push");
  a_lp_drop: assert property (long_push && !LONG_PUSH_RESET // [RQ14]
                              |=> state_q == ST_STANDBY)
    else $error("enable kept after long push");
  a_reconfirm_drop: assert property ((state_q == ST_RECONFIRM) && win_done && !hold // [RQ14]
                                     |=> state_q == ST_STANDBY)
    else $error("enable kept after reconfirm window without hold");
  a_charge_off: assert property (!cap_fit // [RQ1]
                                 |=> !delay_cap_charge_current_en)
    else $error("charge current on without capacitor");
  a_rst_quiet: assert property ((state_q == ST_STANDBY) && (rst_cnt_q == cnt_t'(0)) // [RQ16]
                                |=> !reset_n.oe)
    else $error("reset driven in standby with no pulse pending");

endmodule // pushbutton_power_controller

/* File: verif/pbctl_far_side.sv */
// Far-side model: two push-buttons with pull-ups and a host that confirms power
`timescale 1ns/1ps
module pbctl_far_side #(
  parameter int HOST_DELAY = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Bench controls
  input  wire logic press_btn,
  input  wire logic press_sec,
  input  wire logic host_ok,
  // Device pins
  input  wire logic power_on,
  output logic      power_button_n,
  output logic      second_button_n,
  output logic      hold_confirm_in
);
  int wait_q;

  // Buttons only pull to ground; the pull-up restores the high level on release
  assign power_button_n  = press_btn ? 1'b0 : 1'b1;
  assign second_button_n = press_sec ? 1'b0 : 1'b1;

  // Host boots a few cycles after power arrives; an unpowered host cannot hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q          <= 0;
      hold_confirm_in <= 1'b0;
    end else if (!power_on || !host_ok) begin
      wait_q          <= 0;
      hold_confirm_in <= 1'b0;
    end else if (wait_q < HOST_DELAY) begin
      wait_q <= wait_q + 1;
    end else begin
      hold_confirm_in <= 1'b1;
    end
  end
endmodule // pbctl_far_side

/* File: verif/test_pushbutton_power_controller.sv */
// Self-checking bench for the push-button power controller
`timescale 1ns/1ps
module test_pushbutton_power_controller;
  import pbctl_pkg::*;
  localparam int DEB = 32'h8;
  localparam int INT = 32'h6;
  localparam int REC = 32'h5;
  localparam int WIN = 32'h28;
  typedef struct {int press; bit host; bit sup; bit en; int rst; bit slo;} row_t;
  logic    clk, rstn, sup_up, sup_lo, cap_fit, cap_hit, press_btn, press_sec, host_ok, en_inv;
  logic    power_button_n, second_button_n, hold_confirm_in, enable_out, charge_en;
  od_pin_t reset_n, int_n, supply_low_n, button_state_n;
  int      n_errors, tests_run, n_rst, n_int, n_slo, n_bst;
  row_t    rows[6] = '{
    '{4, 1, 1, 0, 0, 0},
    '{30, 1, 1, 1, REC, 0},
    '{30, 0, 1, 0, REC, 0},
    '{30, 1, 0, 0, 0, 1},
    '{60, 1, 1, 1, REC, 0},
    '{60, 0, 1, 0, REC, 0}
  };

  pushbutton_power_controller #(.DEB_CYC(DEB), .INT_CYC(INT), .REC_CYC(REC), .WIN_CYC(WIN)) dut (
    .clk(clk), .rstn(rstn), .power_button_n(power_button_n), .second_button_n(second_button_n),
    .supply_above_upper(sup_up), .supply_above_lower(sup_lo), .long_push_delay_cap_fitted(cap_fit),
    .delay_cap_threshold_hit(cap_hit), .hold_confirm_in(hold_confirm_in), .enable_out(enable_out),
    .delay_cap_charge_current_en(charge_en), .reset_n(reset_n), .int_n(int_n),
    .supply_low_n(supply_low_n), .button_state_n(button_state_n));

  // Same stimulus with the inverted enable option; its enable must mirror the main one
  pushbutton_power_controller #(.DEB_CYC(DEB), .INT_CYC(INT), .REC_CYC(REC), .WIN_CYC(WIN),
                                .EN_ACTIVE_LOW(1'b1)) dut_inv (
    .clk(clk), .rstn(rstn), .power_button_n(power_button_n), .second_button_n(second_button_n),
    .supply_above_upper(sup_up), .supply_above_lower(sup_lo), .long_push_delay_cap_fitted(cap_fit),
    .delay_cap_threshold_hit(cap_hit), .hold_confirm_in(hold_confirm_in), .enable_out(en_inv),
    .delay_cap_charge_current_en(), .reset_n(), .int_n(), .supply_low_n(), .button_state_n());

  pbctl_far_side far (
    .clk(clk), .rstn(rstn), .press_btn(press_btn), .press_sec(press_sec), .host_ok(host_ok),
    .power_on(enable_out), .power_button_n(power_button_n), .second_button_n(second_button_n),
    .hold_confirm_in(hold_confirm_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle counts of each asserted open-drain output, cleared per scenario
  always @(posedge clk) begin
    n_rst <= n_rst + int'(reset_n.oe);
    n_int <= n_int + int'(int_n.oe);
    n_slo <= n_slo + int'(supply_low_n.oe);
    n_bst <= n_bst + int'(button_state_n.oe);
  end

  // Inputs move 1 ns after the edge so no race with the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic clr();
    n_rst = 0;
    n_int = 0;
    n_slo = 0;
    n_bst = 0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Bounded wait for the enable to reach a level
  task automatic wait_en(input logic v, input int lim);
    int k;
    k = 0;
    while (enable_out !== v && k < lim) begin
      cyc(1);
      k++;
    end
    chk("enable_out", v, enable_out);
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    {sup_up, sup_lo, host_ok} = 3'h7;
    {rstn, cap_fit, cap_hit, press_btn, press_sec} = 5'h00;
    n_errors = 0;
    tests_run = 0;
    clr();
    cyc(10);
    chk("idle outputs", 9'h0aa, {enable_out, reset_n, int_n, supply_low_n, button_state_n});
    cyc(10);
    rstn = 1'b1;
    cyc(3);
    // Power-up attempts from standby, each ended by the host dropping hold
    foreach (rows[i]) begin
      sup_up = rows[i].sup;
      host_ok = rows[i].host;
      clr();
      press_btn = 1'b1;
      cyc(rows[i].press);
      press_btn = 1'b0;
      cyc(8);
      chk("enable_out", rows[i].en, enable_out);
      chk("enable polarity", !enable_out, en_inv);
      chk("reset cycles", rows[i].rst, n_rst);
      chk("supply low seen", rows[i].slo, n_slo != 0);
      host_ok = 1'b0;
      cyc(12);
      chk("enable after hold low", 0, enable_out);
      chk("supply low in standby", 0, supply_low_n.oe);
      sup_up = 1'b1;
      host_ok = 1'b1;
    end
    // Supply dip in mid-debounce restarts the count
    clr();
    press_btn = 1'b1;
    cyc(5);
    sup_up = 1'b0;
    cyc(3);
    sup_up = 1'b1;
    cyc(8);
    chk("enable during restart", 0, enable_out);
    wait_en(1'b1, 12);
    cyc(10);
    chk("int during power-up", 0, n_int);
    press_btn = 1'b0;
    cyc(8);
    chk("enable in run", 1, enable_out);
    chk("enable polarity in run", 0, en_inv);
    // Presses in normal operation: too short, stretched, held
    clr();
    press_btn = 1'b1;
    cyc(3);
    press_btn = 1'b0;
    cyc(10);
    chk("int short press", 0, n_int);
    clr();
    press_btn = 1'b1;
    cyc(12);
    press_btn = 1'b0;
    cyc(12);
    chk("int stretched", 1, n_int >= INT);
    chk("button state stretched", 1, n_bst >= DEB + INT);
    clr();
    press_btn = 1'b1;
    cyc(20);
    press_btn = 1'b0;
    cyc(12);
    chk("int while held", 1, n_int >= 20 - DEB - 2);
    // Long push with the delay capacitor, then without it
    clr();
    cap_fit = 1'b1;
    {press_btn, press_sec} = 2'h3;
    cyc(30);
    chk("reset before cap threshold", 0, n_rst);
    chk("charge current", 1, charge_en);
    cap_hit = 1'b1;
    cyc(6);
    {press_btn, press_sec} = 2'h0;
    cyc(12);
    chk("reset after cap threshold", REC, n_rst);
    chk("enable after reconfirm", 1, enable_out);
    {cap_fit, cap_hit} = 2'h0;
    clr();
    {press_btn, press_sec} = 2'h3;
    cyc(20);
    {press_btn, press_sec} = 2'h0;
    cyc(15);
    chk("reset without cap", REC, n_rst);
    chk("enable after long push", 1, enable_out);
    // Undervoltage: a brief one only interrupts and flags supply low, a long one drops power
    clr();
    sup_lo = 1'b0;
    cyc(3);
    sup_lo = 1'b1;
    cyc(12);
    chk("int on undervoltage", 1, n_int >= INT);
    chk("supply low on undervoltage", 1, n_slo != 0);
    chk("enable after brief dip", 1, enable_out);
    clr();
    sup_lo = 1'b0;
    cyc(2);
    press_btn = 1'b1;
    cyc(5);
    press_btn = 1'b0;
    cyc(5);
    chk("enable before drop time", 1, enable_out);
    wait_en(1'b0, 12);
    chk("button state in undervoltage", 0, n_bst);
    cyc(3);
    chk("supply low in standby", 0, supply_low_n.oe);
    sup_lo = 1'b1;
    cyc(5);
    tally_and_finish();
  end
endmodule // test_pushbutton_power_controller
